// ### design/limit_alarm_evaluator.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`default_nettype none
// Function
// - sixteen independent alarms, channels 5 to 20, each with its own settings.
// - default source of the four alarms of input n is measurement n.
// - each alarm stores a level threshold and a hysteresis value.
// - under alarms set raw condition when value falls below level minus hysteresis.
// - under alarms clear raw condition only when value rises above level plus hysteresis.
// - over alarms set raw condition when value rises above level plus hysteresis.
// - over alarms clear raw condition only when value falls below level minus hysteresis.
// - output asserts only after violation persisted for the ON delay.
// - output deasserts only after input stayed in limits for the OFF delay.
// - asserted output stays on at least the minimum ON time.
// - deasserted output stays off at least the minimum OFF time.
// - summary alarm ORs selected alarms; channel 21; enabled or disabled.
// - summary has a per-alarm mask selecting any subset of channels 5 to 20.
// - summary activation starts warning tone, held until operator acknowledges.
// - each alarm enabled or disabled; disabled never asserts nor feeds summary.
module limit_alarm_evaluator
    import limit_alarm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements and operator
    input wire logic [NUM_INPUTS-1:0][VAL_W-1:0] meas_value,
    input wire logic ack_pulse,
    // alarm outputs
    output logic [NUM_ALARMS-1:0] alarm_out,
    output logic summary_alarm,
    output logic warning_tone
);
    // configuration state
    logic sum_en_reg;
    logic sum_en_next;
    logic [NUM_ALARMS-1:0] sum_mask_reg;
    logic [NUM_ALARMS-1:0] sum_mask_next;
    logic [NUM_ALARMS-1:0] en_reg;
    logic [NUM_ALARMS-1:0] en_next;
    logic [1:0] src_reg [NUM_ALARMS];
    logic [1:0] src_next [NUM_ALARMS];
    alarm_kind_t kind_reg [NUM_ALARMS];
    alarm_kind_t kind_next [NUM_ALARMS];
    logic [VAL_W-1:0] level_reg [NUM_ALARMS];
    logic [VAL_W-1:0] level_next [NUM_ALARMS];
    logic [VAL_W-1:0] hyst_reg [NUM_ALARMS];
    logic [VAL_W-1:0] hyst_next [NUM_ALARMS];
    logic [TIME_W-1:0] ond_reg [NUM_ALARMS];
    logic [TIME_W-1:0] ond_next [NUM_ALARMS];
    logic [TIME_W-1:0] offd_reg [NUM_ALARMS];
    logic [TIME_W-1:0] offd_next [NUM_ALARMS];
    logic [TIME_W-1:0] mon_reg [NUM_ALARMS];
    logic [TIME_W-1:0] mon_next [NUM_ALARMS];
    logic [TIME_W-1:0] moff_reg [NUM_ALARMS];
    logic [TIME_W-1:0] moff_next [NUM_ALARMS];
    // bus state
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    // time base, summary and tone
    logic [31:0] tick_cnt_reg;
    logic [31:0] tick_cnt_next;
    logic tick_reg;
    logic tick_next;
    logic sum_reg;
    logic sum_next;
    logic tone_reg;
    logic tone_next;
    // per-alarm results
    logic [NUM_ALARMS-1:0] alarm_vec;
    logic [NUM_ALARMS-1:0] raw_vec;
    // decode
    logic in_alarm;
    logic [3:0] idx;
    logic [3:0] sub;
    logic wr_en;

    assign in_alarm = (paddr[ADDR_W-1:8] == OFF_ALARM_BASE[ADDR_W-1:8]);
    assign idx = paddr[7:4];
    assign sub = paddr[3:0];
    // writes land at the access edge, when pready is already high
    assign wr_en = psel && penable && pready_reg && pwrite;

    always_comb
    begin
        sum_en_next = sum_en_reg;
        sum_mask_next = sum_mask_reg;
        en_next = en_reg;
        src_next = src_reg;
        kind_next = kind_reg;
        level_next = level_reg;
        hyst_next = hyst_reg;
        ond_next = ond_reg;
        offd_next = offd_reg;
        mon_next = mon_reg;
        moff_next = moff_reg;
        if (wr_en && !pslverr_reg)
        begin
            if (in_alarm)
            begin
                case (sub)
                    SUB_CTRL:
                    begin
                        en_next[idx] = pwdata[CTRL_EN_BIT];
                        src_next[idx] = pwdata[CTRL_SRC_LSB +: 2];
                        kind_next[idx] = alarm_kind_t'(pwdata[CTRL_KIND_LSB +: 2]);
                    end
                    SUB_LIMIT:
                    begin
                        level_next[idx] = pwdata[VAL_W-1:0];
                        hyst_next[idx] = pwdata[HI_HALF_LSB +: VAL_W];
                    end
                    SUB_DELAY:
                    begin
                        ond_next[idx] = pwdata[TIME_W-1:0];
                        offd_next[idx] = pwdata[HI_HALF_LSB +: TIME_W];
                    end
                    SUB_HOLD:
                    begin
                        mon_next[idx] = pwdata[TIME_W-1:0];
                        moff_next[idx] = pwdata[HI_HALF_LSB +: TIME_W];
                    end
                    default:
                    begin
                        en_next = en_reg;
                    end
                endcase
            end
            else if (paddr == OFF_SUM_CTRL)
            begin
                sum_en_next = pwdata[CTRL_EN_BIT];
            end
            else if (paddr == OFF_SUM_MASK)
            begin
                sum_mask_next = pwdata[NUM_ALARMS-1:0];
            end
        end
    end

    always_comb
    begin
        pready_next = psel && !penable;
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (psel && !penable)
        begin
            // status registers are read-only; writes to them are dropped quietly
            if (paddr[1:0] != 2'b00)
            begin
                pslverr_next = 1'b1;
            end
            else if (in_alarm)
            begin
                case (sub)
                    SUB_CTRL:
                    begin
                        prdata_next[CTRL_EN_BIT] = en_reg[idx];
                        prdata_next[CTRL_SRC_LSB +: 2] = src_reg[idx];
                        prdata_next[CTRL_KIND_LSB +: 2] = kind_reg[idx];
                        prdata_next[CTRL_RAW_BIT] = raw_vec[idx];
                        prdata_next[CTRL_OUT_BIT] = alarm_vec[idx];
                    end
                    SUB_LIMIT:
                    begin
                        prdata_next = {hyst_reg[idx], level_reg[idx]};
                    end
                    SUB_DELAY:
                    begin
                        prdata_next = {offd_reg[idx], ond_reg[idx]};
                    end
                    SUB_HOLD:
                    begin
                        prdata_next = {moff_reg[idx], mon_reg[idx]};
                    end
                    default:
                    begin
                        pslverr_next = 1'b1;
                    end
                endcase
            end
            else if (paddr == OFF_SUM_CTRL)
            begin
                prdata_next[CTRL_EN_BIT] = sum_en_reg;
            end
            else if (paddr == OFF_SUM_MASK)
            begin
                prdata_next[NUM_ALARMS-1:0] = sum_mask_reg;
            end
            else if (paddr == OFF_ALARM_STATUS)
            begin
                prdata_next[NUM_ALARMS-1:0] = alarm_vec;
            end
            else if (paddr == OFF_TONE_STATUS)
            begin
                prdata_next[TONE_BIT] = tone_reg;
                prdata_next[SUMMARY_BIT] = sum_reg;
            end
            else
            begin
                pslverr_next = 1'b1;
            end
        end
    end

    always_comb
    begin
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
        if (tick_cnt_reg >= 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_next = 32'h0000_0000;
            tick_next = 1'b1;
        end
        // the evaluator drops a disabled alarm one cycle after en_reg falls, so en_reg masks it here too
        sum_next = sum_en_reg && |(alarm_vec & sum_mask_reg & en_reg);
        tone_next = tone_reg;
        if (ack_pulse)
        begin
            tone_next = 1'b0;
        end
        // a rising edge in the acknowledge cycle wins, so no event is lost
        if (sum_next && !sum_reg)
        begin
            tone_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sum_en_reg <= RST_SUM_EN;
            sum_mask_reg <= RST_SUM_MASK;
            en_reg <= {NUM_ALARMS{RST_ALARM_EN}};
            for (int i = 0; i < NUM_ALARMS; i++)
            begin
                src_reg[i] <= 2'(i / KINDS_PER_INPUT);
                kind_reg[i] <= alarm_kind_t'(2'(i % KINDS_PER_INPUT));
                level_reg[i] <= RST_LEVEL;
                hyst_reg[i] <= RST_HYST;
                ond_reg[i] <= RST_ON_DELAY;
                offd_reg[i] <= RST_OFF_DELAY;
                mon_reg[i] <= RST_MIN_ON;
                moff_reg[i] <= RST_MIN_OFF;
            end
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
            sum_reg <= 1'b0;
            tone_reg <= 1'b0;
        end
        else
        begin
            sum_en_reg <= sum_en_next;
            sum_mask_reg <= sum_mask_next;
            en_reg <= en_next;
            src_reg <= src_next;
            kind_reg <= kind_next;
            level_reg <= level_next;
            hyst_reg <= hyst_next;
            ond_reg <= ond_next;
            offd_reg <= offd_next;
            mon_reg <= mon_next;
            moff_reg <= moff_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            sum_reg <= sum_next;
            tone_reg <= tone_next;
        end
    end

    for (genvar g = 0; g < NUM_ALARMS; g++)
    begin : g_alarm
        alarm_if a_if ();
        assign a_if.enable = en_reg[g];
        assign a_if.over = kind_reg[g][KIND_OVER_BIT];
        assign a_if.tick = tick_reg;
        assign a_if.value = meas_value[src_reg[g]];
        assign a_if.level = level_reg[g];
        assign a_if.hyst = hyst_reg[g];
        assign a_if.on_delay = ond_reg[g];
        assign a_if.off_delay = offd_reg[g];
        assign a_if.min_on = mon_reg[g];
        assign a_if.min_off = moff_reg[g];
        assign alarm_vec[g] = a_if.alarm;
        assign raw_vec[g] = a_if.raw;
        // one evaluator per channel keeps the sixteen alarms independent
        alarm_eval u_eval (
            .clk (pclk),
            .rst_n (presetn),
            .bus (a_if.eval)
        );
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign alarm_out = alarm_vec;
    assign summary_alarm = sum_reg;
    assign warning_tone = tone_reg;
endmodule : limit_alarm_evaluator
`default_nettype wire

// ### common/limit_alarm_pkg.sv
`default_nettype none
package limit_alarm_pkg;
    localparam int NUM_ALARMS = 16;
    localparam int NUM_INPUTS = 4;
    localparam int KINDS_PER_INPUT = 4;
    localparam int VAL_W = 16;
    localparam int TIME_W = 16;
    localparam int ADDR_W = 12;
    // time base
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_MS = 100;
    localparam int TICK_CYCLES_DFLT = TICK_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_SUM_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_SUM_MASK = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_ALARM_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_TONE_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_ALARM_BASE = 12'h100;
    localparam logic [3:0] SUB_CTRL = 4'h0;
    localparam logic [3:0] SUB_LIMIT = 4'h4;
    localparam logic [3:0] SUB_DELAY = 4'h8;
    localparam logic [3:0] SUB_HOLD = 4'hC;
    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_KIND_LSB = 4;
    localparam int CTRL_RAW_BIT = 8;
    localparam int CTRL_OUT_BIT = 9;
    localparam int KIND_OVER_BIT = 1;
    localparam int HI_HALF_LSB = 16;
    localparam int TONE_BIT = 0;
    localparam int SUMMARY_BIT = 1;
    // reset values
    localparam logic RST_SUM_EN = 1'b0;
    localparam logic [NUM_ALARMS-1:0] RST_SUM_MASK = 16'hFFFF;
    localparam logic RST_ALARM_EN = 1'b0;
    localparam logic [VAL_W-1:0] RST_LEVEL = 16'h0000;
    localparam logic [VAL_W-1:0] RST_HYST = 16'h0000;
    localparam logic [TIME_W-1:0] RST_ON_DELAY = 16'h0000;
    localparam logic [TIME_W-1:0] RST_OFF_DELAY = 16'h0000;
    localparam logic [TIME_W-1:0] RST_MIN_ON = 16'h0001;
    localparam logic [TIME_W-1:0] RST_MIN_OFF = 16'h0001;

    typedef enum logic [1:0] {
        KIND_UNDER_FAULT,
        KIND_UNDER_WARNING,
        KIND_OVER_WARNING,
        KIND_OVER_FAULT
    } alarm_kind_t;
endpackage : limit_alarm_pkg
`default_nettype wire

// ### common/alarm_if.sv
`default_nettype none
interface alarm_if;
    import limit_alarm_pkg::*;
    logic enable;
    logic over;
    logic tick;
    logic [VAL_W-1:0] value;
    logic [VAL_W-1:0] level;
    logic [VAL_W-1:0] hyst;
    logic [TIME_W-1:0] on_delay;
    logic [TIME_W-1:0] off_delay;
    logic [TIME_W-1:0] min_on;
    logic [TIME_W-1:0] min_off;
    logic raw;
    logic alarm;

    modport cfg (
        output enable, over, tick, value, level, hyst,
        output on_delay, off_delay, min_on, min_off,
        input raw, alarm
    );
    modport eval (
        input enable, over, tick, value, level, hyst,
        input on_delay, off_delay, min_on, min_off,
        output raw, alarm
    );
endinterface : alarm_if
`default_nettype wire

// ### design/alarm_eval.sv
`default_nettype none
module alarm_eval
    import limit_alarm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and result
    alarm_if.eval bus
);
    typedef enum logic {ST_OFF, ST_ON} out_state_t;

    out_state_t st_reg;
    out_state_t st_next;
    logic raw_reg;
    logic raw_next;
    logic [TIME_W-1:0] qual_reg;
    logic [TIME_W-1:0] qual_next;
    logic [TIME_W-1:0] hold_reg;
    logic [TIME_W-1:0] hold_next;
    logic signed [VAL_W+1:0] val_s;
    logic signed [VAL_W+1:0] lo_s;
    logic signed [VAL_W+1:0] hi_s;
    logic want;
    logic [TIME_W-1:0] delay_lim;
    logic [TIME_W-1:0] hold_lim;

    always_comb
    begin
        // two extra bits so level minus hysteresis may go below zero
        val_s = signed'({2'b00, bus.value});
        lo_s = signed'({2'b00, bus.level}) - signed'({2'b00, bus.hyst});
        hi_s = signed'({2'b00, bus.level}) + signed'({2'b00, bus.hyst});
        raw_next = raw_reg;
        if (!bus.enable)
        begin
            raw_next = 1'b0;
        end
        else if (bus.over)
        begin
            if (!raw_reg && (val_s > hi_s))
            begin
                raw_next = 1'b1;
            end
            else if (raw_reg && (val_s < lo_s))
            begin
                raw_next = 1'b0;
            end
        end
        else
        begin
            if (!raw_reg && (val_s < lo_s))
            begin
                raw_next = 1'b1;
            end
            else if (raw_reg && (val_s > hi_s))
            begin
                raw_next = 1'b0;
            end
        end
    end

    always_comb
    begin
        // registered raw feeds the timing stage: comparator first
        want = raw_reg != (st_reg == ST_ON);
        delay_lim = (st_reg == ST_ON) ? bus.off_delay : bus.on_delay;
        hold_lim = (st_reg == ST_ON) ? bus.min_on : bus.min_off;
        st_next = st_reg;
        qual_next = 16'h0000;
        hold_next = hold_reg;
        if (bus.tick && (hold_reg != 16'hFFFF))
        begin
            hold_next = hold_reg + 1'b1;
        end
        if (want)
        begin
            qual_next = qual_reg;
            if (bus.tick && (qual_reg != 16'hFFFF))
            begin
                qual_next = qual_reg + 1'b1;
            end
        end
        case (st_reg)
            ST_OFF:
            begin
                if (want && (qual_reg >= delay_lim) && (hold_reg >= hold_lim))
                begin
                    st_next = ST_ON;
                    qual_next = 16'h0000;
                    hold_next = 16'h0000;
                end
            end
            ST_ON:
            begin
                if (want && (qual_reg >= delay_lim) && (hold_reg >= hold_lim))
                begin
                    st_next = ST_OFF;
                    qual_next = 16'h0000;
                    hold_next = 16'h0000;
                end
            end
            default:
            begin
                st_next = ST_OFF;
            end
        endcase
        if (!bus.enable)
        begin
            st_next = ST_OFF;
            qual_next = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= ST_OFF;
            raw_reg <= 1'b0;
            qual_reg <= 16'h0000;
            hold_reg <= 16'h0000;
        end
        else
        begin
            st_reg <= st_next;
            raw_reg <= raw_next;
            qual_reg <= qual_next;
            hold_reg <= hold_next;
        end
    end

    assign bus.alarm = (st_reg == ST_ON);
    assign bus.raw = raw_reg;
endmodule : alarm_eval
`default_nettype wire

// ### sim/limit_alarm_evaluator_properties.sv
`default_nettype none
module limit_alarm_evaluator_properties
    import limit_alarm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // measurements and alarms
    input wire logic [NUM_INPUTS-1:0][VAL_W-1:0] meas_value,
    input wire logic ack_pulse,
    input wire logic [NUM_ALARMS-1:0] alarm_out,
    input wire logic summary_alarm,
    input wire logic warning_tone
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_setup: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single pulse after setup");
    chk_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'b00
        |=> pslverr && prdata == 32'h0000_0000) else $error("unaligned access not refused");
    chk_status_read: assert property (
        psel && !penable && !pwrite && paddr == OFF_ALARM_STATUS
        |=> prdata[15:0] == $past(alarm_out)) else $error("status read wrong");
    chk_summary_src: assert property ($rose(summary_alarm) |-> $past(alarm_out) != '0)
        else $error("summary rose without alarm");
    chk_summary_idle: assert property (alarm_out == '0 |=> !summary_alarm)
        else $error("summary high with no alarm");
    chk_tone_set: assert property ($rose(summary_alarm) |-> warning_tone)
        else $error("tone not started");
    chk_tone_hold: assert property (warning_tone && !ack_pulse |=> warning_tone)
        else $error("tone dropped without acknowledge");
    chk_tone_ack: assert property (
        warning_tone && ack_pulse |=> !warning_tone || $rose(summary_alarm))
        else $error("tone not cleared by acknowledge");
endmodule : limit_alarm_evaluator_properties

bind limit_alarm_evaluator limit_alarm_evaluator_properties u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_value(meas_value), .ack_pulse(ack_pulse), .alarm_out(alarm_out),
    .summary_alarm(summary_alarm), .warning_tone(warning_tone));
`default_nettype wire

// ### sim/meas_source.sv
`default_nettype none
module meas_source
    import limit_alarm_pkg::*;
(
    // clock
    input wire logic clk,
    // toward the block
    output logic [NUM_INPUTS-1:0][VAL_W-1:0] meas_value,
    output logic ack_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        meas_value = {NUM_INPUTS{16'h0064}};
        ack_pulse = 1'b0;
    end
    task automatic set_meas(input int idx, input logic [VAL_W-1:0] v);
        @(posedge clk);
        meas_value[idx] <= v;
    endtask : set_meas
    // operator reacts after a chosen delay, one-cycle press
    task automatic acknowledge(input int delay);
        repeat (delay) @(posedge clk);
        ack_pulse <= 1'b1;
        @(posedge clk);
        ack_pulse <= 1'b0;
    endtask : acknowledge
endmodule : meas_source
`default_nettype wire

// ### sim/limit_alarm_evaluator_tb.sv
`default_nettype none
module limit_alarm_evaluator_tb
    import limit_alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // short tick keeps delay counts fast in simulation
    localparam int TICKS = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ack_pulse;
    logic summary_alarm, warning_tone;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [NUM_INPUTS-1:0][VAL_W-1:0] meas_value;
    logic [NUM_ALARMS-1:0] alarm_out;
    int fails, checks_done;

    limit_alarm_evaluator #(.TICK_CYCLES(TICKS)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_value(meas_value),
        .ack_pulse(ack_pulse), .alarm_out(alarm_out), .summary_alarm(summary_alarm),
        .warning_tone(warning_tone));
    meas_source u_src (.clk(pclk), .meas_value(meas_value), .ack_pulse(ack_pulse));

    always #2 pclk = ~pclk;

    task automatic test_done();
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : check

    task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fails++;
            test_done();
        end
    endtask : apb_xfer

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b1, a, d, rd, err);
    endtask : reg_wr

    task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rd;
        logic err;
        apb_xfer(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, e});
    endtask : reg_chk

    function automatic logic [ADDR_W-1:0] alarm_addr(input int i, input logic [3:0] sub);
        return OFF_ALARM_BASE + ADDR_W'(16 * i) + ADDR_W'(sub);
    endfunction : alarm_addr

    function automatic logic [31:0] ctrl_word(input int i, input logic en);
        return {26'h0, 2'(i % 4), 2'(i / 4), 1'b0, en};
    endfunction : ctrl_word

    task automatic cfg_alarm(input int i, input logic [31:0] lim, dly, hold);
        reg_wr(alarm_addr(i, SUB_LIMIT), lim);
        reg_wr(alarm_addr(i, SUB_DELAY), dly);
        reg_wr(alarm_addr(i, SUB_HOLD), hold);
        reg_wr(alarm_addr(i, SUB_CTRL), ctrl_word(i, 1'b1));
    endtask : cfg_alarm

    task automatic wait_level(input int b, input logic lvl, input int maxc, output int cyc);
        cyc = 0;
        while (alarm_out[b] !== lvl && cyc < maxc)
        begin
            @(posedge pclk);
            cyc++;
        end
        if (alarm_out[b] !== lvl)
        begin
            fails++;
            test_done();
        end
    endtask : wait_level

    task automatic hold_level(input int b, input logic lvl, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            check(32'(alarm_out[b]), 32'(lvl));
        end
    endtask : hold_level

    task automatic test_reset_values();
        check(32'(alarm_out), 32'h0000_0000);
        for (int i = 0; i < NUM_ALARMS; i++)
            reg_chk(alarm_addr(i, SUB_CTRL), ctrl_word(i, 1'b0), 1'b0);
        reg_chk(alarm_addr(0, SUB_HOLD), 32'h0001_0001, 1'b0);
        reg_chk(alarm_addr(15, SUB_LIMIT), 32'h0000_0000, 1'b0);
        reg_chk(OFF_SUM_MASK, 32'h0000_FFFF, 1'b0);
        reg_chk(OFF_SUM_CTRL, 32'h0000_0000, 1'b0);
        reg_wr(OFF_ALARM_STATUS, 32'hFFFF_FFFF);
        reg_chk(OFF_ALARM_STATUS, 32'h0000_0000, 1'b0);
        reg_chk(12'h010, 32'h0000_0000, 1'b1);
        reg_chk(12'h002, 32'h0000_0000, 1'b1);
    endtask : test_reset_values

    task automatic test_hysteresis();
        logic [VAL_W-1:0] v [7] = '{16'h0064, 16'h005A, 16'h0059, 16'h006E, 16'h006F,
            16'h005A, 16'h0059};
        logic [3:0] e [7] = '{4'h0, 4'h0, 4'h3, 4'h3, 4'hC, 4'hC, 4'h3};
        for (int k = 4; k < 8; k++)
            cfg_alarm(k, 32'h000A_0064, 32'h0000_0000, 32'h0000_0000);
        for (int k = 0; k < 7; k++)
        begin
            u_src.set_meas(1, v[k]);
            repeat (4) @(posedge pclk);
            check(32'(alarm_out[7:4]), 32'(e[k]));
        end
    endtask : test_hysteresis

    task automatic test_timing();
        int cyc;
        cfg_alarm(8, 32'h0000_0064, 32'h0003_0003, 32'h0006_0005);
        u_src.set_meas(2, 16'h0032);
        repeat (TICKS) @(posedge pclk);
        u_src.set_meas(2, 16'h0096);
        hold_level(8, 1'b0, 30);
        u_src.set_meas(2, 16'h0032);
        wait_level(8, 1'b1, 40, cyc);
        check(32'(cyc >= 2 * TICKS), 32'h0000_0001);
        u_src.set_meas(2, 16'h0096);
        hold_level(8, 1'b1, 4 * TICKS);
        wait_level(8, 1'b0, 40, cyc);
        u_src.set_meas(2, 16'h0032);
        hold_level(8, 1'b0, 5 * TICKS - 2);
        wait_level(8, 1'b1, 60, cyc);
        repeat (6 * TICKS) @(posedge pclk);
        u_src.set_meas(2, 16'h0096);
        repeat (TICKS) @(posedge pclk);
        u_src.set_meas(2, 16'h0032);
        hold_level(8, 1'b1, 6 * TICKS);
    endtask : test_timing

    task automatic test_summary();
        cfg_alarm(12, 32'h0000_0064, 32'h0000_0000, 32'h0000_0000);
        reg_wr(OFF_SUM_MASK, 32'h0000_2000);
        reg_wr(OFF_SUM_CTRL, 32'h0000_0001);
        u_src.set_meas(3, 16'h0032);
        repeat (4) @(posedge pclk);
        check({31'h0, summary_alarm}, 32'h0000_0000);
        reg_chk(OFF_ALARM_STATUS, 32'h0000_1130, 1'b0);
        reg_chk(alarm_addr(12, SUB_CTRL), 32'h0000_030D, 1'b0);
        reg_wr(OFF_SUM_MASK, 32'h0000_1000);
        repeat (3) @(posedge pclk);
        check({30'h0, summary_alarm, warning_tone}, 32'h0000_0003);
        u_src.acknowledge(3);
        repeat (2) @(posedge pclk);
        reg_chk(OFF_TONE_STATUS, 32'h0000_0002, 1'b0);
        reg_wr(OFF_SUM_CTRL, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        check({31'h0, summary_alarm}, 32'h0000_0000);
        reg_wr(OFF_SUM_CTRL, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        check({30'h0, summary_alarm, warning_tone}, 32'h0000_0003);
        u_src.acknowledge(0);
        reg_wr(alarm_addr(12, SUB_CTRL), ctrl_word(12, 1'b0));
        repeat (3) @(posedge pclk);
        check({29'h0, alarm_out[12], summary_alarm, warning_tone}, 32'h0000_0000);
    endtask : test_summary

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fails = 0;
        checks_done = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_values();
        test_hysteresis();
        test_timing();
        test_summary();
        test_done();
    end
endmodule : limit_alarm_evaluator_tb
`default_nettype wire
